// ### logic/wdt_map.svh
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Timeout exponents per select code, in system clock cycles.
`define WDT_EXP_SEL0 5'd15
`define WDT_EXP_SEL1 5'd18
`define WDT_EXP_SEL2 5'd21
`define WDT_EXP_SEL3 5'd24
// Reset window after the interrupt timeout, in system clock cycles.
`define WDT_RESET_WINDOW 512
// Width of the main counter, enough for the longest timeout.
`define WDT_CNT_W 25
// Reset value of the timeout select field.
`define WDT_SEL_RESET 2'h0

`endif

// ### logic/wdt_pkg.sv
package wdt_pkg;
  // Phase of the watchdog sequence.
  typedef enum logic [1:0] {
    WD_OFF,
    WD_COUNT,
    WD_WINDOW,
    WD_FIRED
  } wd_state_type;
endpackage

// ### logic/wdt_window_counter.sv
`timescale 1ns/1ps
`include "wdt_map.svh"

// Counts the reset window and pulses done on its last cycle.
module wdt_window_counter #(
  parameter int WINDOW = `WDT_RESET_WINDOW
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  output logic done
);
  localparam int CW = $clog2(WINDOW + 1);
  logic [CW-1:0] cnt_r;

  // A one-cycle window would make its first and last cycle coincide.
  if (WINDOW < 2) begin : g_window_check
    $error("window too short");
  end

  // Counts while run is high, clears when it drops.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (!run) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign done = run && (cnt_r == CW'(WINDOW - 1));
endmodule

// ### logic/system_watchdog_timer.sv
`timescale 1ns/1ps
`include "wdt_map.svh"

module system_watchdog_timer
  import wdt_pkg::*;
#(
  parameter int WINDOW = `WDT_RESET_WINDOW
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wd_enable,
  input wire logic reset_enable,
  input wire logic irq_enable,
  input wire logic restart,
  input wire logic [1:0] timeout_select,
  input wire logic irq_clear,
  output logic irq,
  output logic sys_reset,
  output logic timeout_flag
);

  // The window counter needs two cycles at least to tell its first cycle from its last.
  if (WINDOW < 2) begin : g_window_check
    $error("reset window shorter than two cycles");
  end

  ////////////////////////////////////////////////////////////////////////
  // Timeout decode.

  // Maps a select code onto the terminal count of the main counter.
  function automatic logic [`WDT_CNT_W-1:0] term_count(input logic [1:0] sel);
    logic [4:0] e;
    e = `WDT_EXP_SEL0;
    unique case (sel)
      2'h0: e = `WDT_EXP_SEL0;
      2'h1: e = `WDT_EXP_SEL1;
      2'h2: e = `WDT_EXP_SEL2;
      2'h3: e = `WDT_EXP_SEL3;
    endcase
    term_count = (`WDT_CNT_W'(1) << e) - `WDT_CNT_W'(1);
  endfunction

  wd_state_type state_r;
  logic [`WDT_CNT_W-1:0] cnt_r;
  logic [`WDT_CNT_W-1:0] term;
  logic expire;
  logic window_done;
  logic irq_r;
  logic sys_reset_r;
  logic flag_r;

  // The terminal count follows the select code live, so a change in mid-count acts at once.
  assign term = term_count(timeout_select);
  assign expire = (state_r == WD_COUNT) && (cnt_r == term);

  ////////////////////////////////////////////////////////////////////////
  // Main counter; restart wins over counting so a late restart still rescues.

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (!wd_enable || restart || state_r != WD_COUNT) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequence control.

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= WD_OFF;
    end else if (!wd_enable) begin
      state_r <= WD_OFF;
    end else if (restart && state_r != WD_FIRED) begin
      state_r <= WD_COUNT;
    end else begin
      unique case (state_r)
        WD_OFF: state_r <= WD_COUNT;
        WD_COUNT: if (expire) state_r <= WD_WINDOW;
        WD_WINDOW: if (window_done) state_r <= WD_FIRED;
        WD_FIRED: state_r <= WD_FIRED;
      endcase
    end
  end

  wdt_window_counter #(.WINDOW(WINDOW)) u_window (
    .mclk(mclk),
    .rst(rst),
    .run(state_r == WD_WINDOW && !restart),
    .done(window_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sticky timeout flag and interrupt; a new timeout wins over a clear.

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (expire) begin
      flag_r <= 1'b1;
    end else if (irq_clear) begin
      flag_r <= 1'b0;
    end
  end

  // The interrupt follows the next value of the flag, so a clear or a new timeout shows without lag.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (flag_r || expire) && irq_enable && !(irq_clear && !expire);
    end
  end

  // Reset is held once fired; the system reset is expected to clear us via rst.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sys_reset_r <= 1'b0;
    end else begin
      sys_reset_r <= reset_enable && (state_r == WD_FIRED || window_done);
    end
  end

  assign irq = irq_r;
  assign sys_reset = sys_reset_r;
  assign timeout_flag = flag_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  // Helper logic for the checks; it is kept apart from the window counter so that a fault there shows.
  localparam int AW = $clog2(WINDOW + 1);
  logic [AW-1:0] win_age_r;
  logic [4:0] chk_exp;
  logic [`WDT_CNT_W-1:0] chk_term;

  // Reference terminal count worked out arithmetically rather than through the decode function.
  assign chk_exp = `WDT_EXP_SEL0 + 5'(timeout_select) * (`WDT_EXP_SEL1 - `WDT_EXP_SEL0);
  assign chk_term = (`WDT_CNT_W'(1) << chk_exp) - `WDT_CNT_W'(1);

  // Age of the reset window in cycles; it saturates so a long window cannot wrap it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      win_age_r <= '0;
    end else if (state_r == WD_WINDOW && win_age_r != AW'(WINDOW)) begin
      win_age_r <= win_age_r + 1'b1;
    end else if (state_r != WD_WINDOW) begin
      win_age_r <= '0;
    end
  end

  a_reset_timing: assert property (@(posedge mclk) disable iff (rst)
    (state_r == WD_WINDOW && !restart && wd_enable && reset_enable) |=>
      (sys_reset == (win_age_r == AW'(WINDOW))))
    else $error("reset not one full window after timeout");

  a_restart_clears: assert property (@(posedge mclk) disable iff (rst)
    (restart && wd_enable && state_r != WD_FIRED) |=> (cnt_r == '0 && state_r == WD_COUNT))
    else $error("restart did not clear counter");

  a_irq_gated: assert property (@(posedge mclk) disable iff (rst)
    !irq_enable |=> !irq)
    else $error("irq raised while disabled");

  a_expire_term: assert property (@(posedge mclk) disable iff (rst)
    (state_r == WD_COUNT) |-> (expire == (cnt_r == chk_term)))
    else $error("timeout at wrong count");

  a_flag_sets: assert property (@(posedge mclk) disable iff (rst)
    expire |=> flag_r)
    else $error("flag missed timeout");

  a_counter_runs: assert property (@(posedge mclk) disable iff (rst)
    (state_r == WD_COUNT && wd_enable && !restart && !expire) |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("counter stalled");

  a_window_fire: assert property (@(posedge mclk) disable iff (rst)
    (window_done && reset_enable) |=> sys_reset)
    else $error("no reset after window");

  a_no_early_reset: assert property (@(posedge mclk) disable iff (rst)
    (state_r == WD_COUNT) |=> !sys_reset)
    else $error("reset during count");

  // Once fired, the reset stands and restarts no longer help.
  a_reset_holds: assert property (@(posedge mclk) disable iff (rst)
    (state_r == WD_FIRED && wd_enable && reset_enable) |=> sys_reset)
    else $error("reset dropped after firing");

  a_restart_ignored: assert property (@(posedge mclk) disable iff (rst)
    (state_r == WD_FIRED && wd_enable) |=> (state_r == WD_FIRED))
    else $error("fired state left without reset");

  // A restart inside the window cancels the pending reset.
  a_window_rescue: assert property (@(posedge mclk) disable iff (rst)
    (state_r == WD_WINDOW && restart && wd_enable) |=> (state_r == WD_COUNT && !sys_reset))
    else $error("restart in window did not rescue");

  // Flag and interrupt behaviour.
  a_clear_flag: assert property (@(posedge mclk) disable iff (rst)
    (irq_clear && !expire) |=> !timeout_flag)
    else $error("flag not cleared");

  a_irq_follows: assert property (@(posedge mclk) disable iff (rst)
    irq_enable |=> (irq == timeout_flag))
    else $error("irq does not follow flag");

  // Enable handling of the free-running counter.
  a_count_start: assert property (@(posedge mclk) disable iff (rst)
    (state_r == WD_OFF && wd_enable) |=> (state_r == WD_COUNT && cnt_r == '0))
    else $error("counter did not start from zero");

  a_off_clears: assert property (@(posedge mclk) disable iff (rst)
    !wd_enable |=> (state_r == WD_OFF && cnt_r == '0))
    else $error("disabled watchdog kept counting");
endmodule

// ### tb/tb_system_watchdog_timer.sv
`timescale 1ns/1ps
module tb_system_watchdog_timer;
  localparam int W = 8;
  localparam int TMO = 32768;
  logic mclk = 1'b0, rst = 1'b1, wd_enable = 1'b0, reset_enable = 1'b1, irq_enable = 1'b0;
  logic restart = 1'b0, irq_clear = 1'b0, irq, sys_reset, timeout_flag;
  logic [1:0] timeout_select = 2'h0;
  logic [31:0] seed = 32'h1f4b;
  int err_total = 0, checks = 0, cnt = -1, win = 0;
  logic m_flag = 1'b0, m_fire = 1'b0, m_irq = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // A short window keeps the run small; expectations all follow from W.
  system_watchdog_timer #(.WINDOW(W)) u_dut (.mclk(mclk), .rst(rst), .wd_enable(wd_enable),
    .reset_enable(reset_enable), .irq_enable(irq_enable), .restart(restart),
    .timeout_select(timeout_select), .irq_clear(irq_clear), .irq(irq), .sys_reset(sys_reset),
    .timeout_flag(timeout_flag));

  always #5 mclk = ~mclk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Timeout length in cycles for a select code.
  function automatic int tmo_of(input logic [1:0] sel);
    return 1 << (15 + 3 * sel);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reference model; it sees the inputs as the design sampled them.
  // The count stays idle until the first restart, so the enable latency never matters.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt = -1;
      win = 0;
      m_flag = 1'b0;
      m_fire = 1'b0;
      m_irq = 1'b0;
    end else begin
      if (irq_clear) m_flag = 1'b0;
      if (!wd_enable) begin
        cnt = -1;
        win = 0;
      end else if (!m_fire) begin
        if (restart) begin
          cnt = 0;
          win = 0;
        end else if (win == W) m_fire = reset_enable;
        else if (win > 0) win++;
        else if (cnt == tmo_of(timeout_select) - 1) begin
          m_flag = 1'b1;
          win = 1;
          cnt = TMO;
        end else if (cnt >= 0) cnt++;
      end
      m_irq = m_flag & irq_enable;
    end
  end

  task automatic cmp(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Outputs are compared once the edge's updates have landed.
  always @(posedge mclk) begin
    #1;
    if (!rst) begin
      cmp(timeout_flag, m_flag);
      cmp(irq, m_irq);
      cmp(sys_reset, m_fire);
    end
  end

  task automatic pulse_restart();
    restart <= 1'b1;
    @(posedge mclk);
    restart <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // A slower code must not time out at the shortest period; then a masked timeout, a rescue, a real fire.
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    wd_enable <= 1'b1;
    repeat (5) @(posedge mclk);
    seed = xs(seed);
    timeout_select <= seed[1:0] | 2'h1;
    pulse_restart();
    seed = xs(seed);
    repeat (TMO + 100 + seed[7:0]) @(posedge mclk);
    timeout_select <= 2'h0;
    pulse_restart();
    repeat (TMO + 3) @(posedge mclk);
    pulse_restart();
    seed = xs(seed);
    repeat (seed[5:0] + 2) @(posedge mclk);
    irq_clear <= 1'b1;
    @(posedge mclk);
    irq_clear <= 1'b0;
    irq_enable <= 1'b1;
    repeat (TMO + W + 10) @(posedge mclk);
    pulse_restart();
    repeat (10) @(posedge mclk);
    tally_and_finish();
  end

  // A hang is cut short just after the longest expected run of about 98.8k cycles.
  initial begin
    #996000;
    err_total++;
    tally_and_finish();
  end
endmodule
